// ===== stc_pkg.sv
// package of constants and carrier types for the 16-bit timer/counter
// What this block does
// - count pair climbs 0000h to FFFFh, wraps to 0000h, flags each wrap
// - overflow latched in flag bit 0, interrupt only while enable bit 0 set
// - source select 0 counts instruction cycles, 1 counts external rising edges
// - control bit 0 runs the counter when set, stops it when clear
// - control bits 5-4 prescale input: 1:1, 1:2, 1:4, 1:8
// - oscillator enable bit 3 runs oscillator, forces pins to inputs reading 0
// - sync bit 2 picks synchronized (0) or not (1); ignored for internal source
// - after enabling external counting, a falling edge must precede any increment
// - external count input is oscillator pin if enabled, else clock pin
// - prescaler counts raw input edges; synchronization follows the prescaler
// - synchronized counter mode stops counting in sleep; prescaler keeps going
// - unsynchronized mode counts through sleep; overflow can wake the processor
// - counter not offered as time base in unsynchronized counter mode
// - either of two capture/compare units can reset the counter
// - control bits 7 and 6 read as zero
// - compare trigger clears counter without flag; a coinciding write wins
// - counter keeps value through resets; control clears to 00h on power-on
// - any write to either counter half clears the prescaler
package stc_pkg;

  localparam int ADDR_W = 8;

  // register byte addresses
  localparam logic [ADDR_W-1:0] OFF_CONTROL = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_COUNT_LO = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_COUNT_HI = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_FLAGS = 8'h1C;
  localparam logic [ADDR_W-1:0] OFF_ENABLES = 8'h20;

  // control field positions, then the overflow bit position in the flag and enable registers
  localparam int POS_ON = 0;
  localparam int POS_CS = 1;
  localparam int POS_SYNC = 2;
  localparam int POS_OSC = 3;
  localparam int POS_PRE_LO = 4;
  localparam int POS_PRE_HI = 5;
  localparam int POS_OVF = 0;

  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam logic [15:0] COUNT_ZERO = 16'h0000;
  localparam logic [2:0] PRE_ZERO = 3'h0;

  typedef struct packed {
    logic [1:0] prescale_select;
    logic osc_enable;
    logic sync_disable;
    logic clock_source_select;
    logic counter_on;
  } stc_ctrl_t;

  typedef struct packed {
    stc_ctrl_t ctrl;
    logic overflow_flag;
    logic overflow_irq_enable;
    logic [2:0] pre;
    logic src_prev;
    logic armed;
    logic [31:0] prdata;
    logic pslverr;
  } stc_state_t;

endpackage

// ===== stc_top.sv
// 16-bit timer/counter with prescaler, apb registers and overflow interrupt
`timescale 1ns/100ps
module stc_top
  import stc_pkg::*;
(
  input wire logic pclk,                 // bus and instruction clock
  input wire logic presetn,              // power-on reset, active low
  input wire logic psel,                 // apb select
  input wire logic penable,              // apb access phase
  input wire logic pwrite,               // apb direction
  input wire logic [ADDR_W-1:0] paddr,   // apb byte address
  input wire logic [31:0] pwdata,        // apb write data
  output logic [31:0] prdata,            // apb read data
  output logic pready,                   // apb ready
  output logic pslverr,                  // apb error, unmapped address
  input wire logic ext_clock_pin,        // external count clock
  input wire logic osc_in_pin,           // low-power oscillator input
  input wire logic sleep,                // processor asleep
  input wire logic [1:0] ccp_event,      // compare special event triggers
  output logic osc_run,                  // oscillator inverter on
  output logic pin_force_input,          // both osc pins forced to inputs
  output logic pin_read_zero,            // osc pins read back as zero
  output logic [15:0] count_value,       // counter for capture/compare
  output logic timebase_valid,           // count usable as time base
  output logic irq,                      // overflow interrupt, level
  output logic wake                      // wake request during sleep
);

  ////////////////////////////////////////////////////////////////////////
  // state
  stc_state_t s;
  stc_state_t next_s;
  logic [15:0] count;
  logic [15:0] next_count;

  logic setup;
  logic wr;
  logic wr_lo;
  logic wr_hi;
  logic src;
  logic src_rise;
  logic src_fall;
  logic ext_mode;
  logic src_tick;
  logic pre_tick;
  logic inc;
  logic ccp_clear;
  logic [2:0] pre_mask;

  function automatic logic [31:0] read_mux(input stc_state_t st,
                                           input logic [15:0] cnt,
                                           input logic [ADDR_W-1:0] a);
    logic [31:0] r;
    r = 32'h0000_0000;
    unique case (a)
      OFF_CONTROL: r = {26'h0, st.ctrl};
      OFF_COUNT_LO: r = {24'h0, cnt[7:0]};
      OFF_COUNT_HI: r = {24'h0, cnt[15:8]};
      OFF_FLAGS: r = {31'h0, st.overflow_flag};
      OFF_ENABLES: r = {31'h0, st.overflow_irq_enable};
      default: r = 32'h0000_0000;
    endcase
    return r;
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    return (a == OFF_CONTROL) || (a == OFF_COUNT_LO) ||
           (a == OFF_COUNT_HI) || (a == OFF_FLAGS) || (a == OFF_ENABLES);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // bus decode: read data is latched in setup, writes land in access
  assign setup = psel && !penable;
  assign wr = psel && penable && pwrite && mapped(paddr);
  assign wr_lo = wr && (paddr == OFF_COUNT_LO);
  assign wr_hi = wr && (paddr == OFF_COUNT_HI);
  assign pready = 1'b1;
  assign prdata = s.prdata;
  assign pslverr = s.pslverr && psel && penable;

  ////////////////////////////////////////////////////////////////////////
  // count source and prescaler
  // the prescaler is clocked by detected input edges, not by the raw pin,
  // so one clock domain serves the whole block; pins must be slow
  assign ext_mode = s.ctrl.clock_source_select;
  assign src = s.ctrl.osc_enable ? osc_in_pin : ext_clock_pin;
  assign src_rise = src && !s.src_prev;
  assign src_fall = !src && s.src_prev;
  // internal source runs on the instruction clock, which stops in sleep
  assign src_tick = s.ctrl.counter_on &&
                    (ext_mode ? (src_rise && s.armed) : !sleep);
  assign pre_mask = (s.ctrl.prescale_select == 2'b00) ? 3'h0 :
                    (s.ctrl.prescale_select == 2'b01) ? 3'h1 :
                    (s.ctrl.prescale_select == 2'b10) ? 3'h3 : 3'h7;
  assign pre_tick = src_tick && ((s.pre & pre_mask) == pre_mask);
  // the synchronizer sits after the prescaler and is dead in sleep;
  // unsynchronized counting ignores the phase clocks altogether
  assign inc = pre_tick &&
               (!ext_mode || s.ctrl.sync_disable || !sleep);
  assign ccp_clear = |ccp_event;

  ////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    next_s = s;
    next_s.src_prev = src;
    // arming restarts whenever counting or the external source is dropped
    if (!s.ctrl.counter_on || !ext_mode) begin
      next_s.armed = 1'b0;
    end else if (src_fall) begin
      next_s.armed = 1'b1;
    end
    if (src_tick) begin
      next_s.pre = s.pre + 3'h1;
    end
    if (wr_lo || wr_hi) begin
      next_s.pre = PRE_ZERO;
    end
    if (setup) begin
      next_s.prdata = read_mux(s, count, paddr);
      next_s.pslverr = !mapped(paddr);
    end
    if (wr && paddr == OFF_CONTROL) begin
      next_s.ctrl = stc_ctrl_t'(pwdata[POS_PRE_HI:POS_ON]);
    end
    if (wr && paddr == OFF_ENABLES) begin
      next_s.overflow_irq_enable = pwdata[POS_OVF];
    end
    // write-one-to-clear; a wrap in the same cycle keeps the flag set
    if (wr && paddr == OFF_FLAGS && pwdata[POS_OVF]) begin
      next_s.overflow_flag = 1'b0;
    end
    if (inc && count == COUNT_MAX && !wr_lo && !wr_hi && !ccp_clear) begin
      next_s.overflow_flag = 1'b1;
    end
  end

  always_comb begin
    next_count = count;
    if (wr_lo || wr_hi) begin
      // a write wins over both the increment and a compare trigger
      if (wr_lo) begin
        next_count[7:0] = pwdata[7:0];
      end
      if (wr_hi) begin
        next_count[15:8] = pwdata[7:0];
      end
    end else if (ccp_clear) begin
      next_count = COUNT_ZERO;
    end else if (inc) begin
      next_count = count + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.ctrl <= stc_ctrl_t'(CONTROL_RESET[5:0]);
    end else begin
      s <= next_s;
    end
  end

  // the count pair has no reset at all, so it survives every reset
  always_ff @(posedge pclk) begin
    count <= next_count;
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  assign osc_run = s.ctrl.osc_enable;
  assign pin_force_input = s.ctrl.osc_enable;
  assign pin_read_zero = s.ctrl.osc_enable;
  assign count_value = count;
  assign timebase_valid = !(ext_mode && s.ctrl.sync_disable);
  assign irq = s.overflow_flag && s.overflow_irq_enable;
  assign wake = irq && sleep;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  wrap_flag_a: assert property (
    inc && count == COUNT_MAX && !wr_lo && !wr_hi && !ccp_clear
    |=> count == COUNT_ZERO && s.overflow_flag)
    else $error("wrap did not clear count and set flag");

  irq_gate_a: assert property (
    irq == (s.overflow_flag && s.overflow_irq_enable))
    else $error("interrupt not gated by enable bit");

  off_hold_a: assert property (
    !s.ctrl.counter_on && !wr_lo && !wr_hi && !ccp_clear
    |=> count == $past(count))
    else $error("counter moved while stopped");

  timer_step_a: assert property (
    s.ctrl.counter_on && !ext_mode && !sleep && pre_mask == 3'h0 &&
    !wr_lo && !wr_hi && !ccp_clear
    |=> count == $past(count) + 16'h0001)
    else $error("timer mode did not step each cycle");

  first_fall_a: assert property (
    ext_mode && !s.armed |-> !inc)
    else $error("increment before first falling edge");

  sync_sleep_a: assert property (
    sleep && ext_mode && !s.ctrl.sync_disable |-> !inc)
    else $error("synchronized counter moved in sleep");

  ctrl_zero_a: assert property (
    setup && paddr == OFF_CONTROL |=> s.prdata[7:6] == 2'b00)
    else $error("unimplemented control bits read nonzero");

  ccp_clear_a: assert property (
    ccp_clear && !wr_lo && !wr_hi && !s.overflow_flag
    |=> count == COUNT_ZERO && !s.overflow_flag)
    else $error("compare trigger did not clear count cleanly");

  pre_clear_a: assert property (
    wr_lo || wr_hi |=> s.pre == PRE_ZERO)
    else $error("counter write left prescaler count");

  timebase_a: assert property (
    ext_mode && s.ctrl.sync_disable |-> !timebase_valid)
    else $error("async count offered as time base");

  osc_pins_a: assert property (
    s.ctrl.osc_enable |-> osc_run && pin_force_input && pin_read_zero)
    else $error("oscillator enable did not take the pins");

  prescale_a: assert property (
    s.ctrl.prescale_select == 2'b11 && src_tick && s.pre != 3'h7
    |-> !pre_tick)
    else $error("1:8 prescale passed an early tick");

  osc_off_a: assert property (
    !s.ctrl.osc_enable |-> !osc_run && !pin_force_input && !pin_read_zero)
    else $error("oscillator outputs active while disabled");

  timebase_int_a: assert property (
    !ext_mode |-> timebase_valid)
    else $error("internal count withheld as time base");

  ////////////////////////////////////////////////////////////////////////
  // flag, enable and control bookkeeping

  flag_sticky_a: assert property (
    s.overflow_flag && !(wr && paddr == OFF_FLAGS && pwdata[POS_OVF])
    |=> s.overflow_flag)
    else $error("overflow flag dropped without a clear");

  flag_clear_a: assert property (
    wr && paddr == OFF_FLAGS && pwdata[POS_OVF] &&
    !(inc && count == COUNT_MAX)
    |=> !s.overflow_flag)
    else $error("writing one did not clear the flag");

  // a wrap and a clear in one cycle: the event must not be lost
  set_wins_a: assert property (
    wr && paddr == OFF_FLAGS && inc && count == COUNT_MAX && !ccp_clear
    |=> s.overflow_flag)
    else $error("clear beat a same-cycle wrap");

  flag_rise_a: assert property (
    $rose(s.overflow_flag)
    |-> count == COUNT_ZERO && $past(count) == COUNT_MAX)
    else $error("flag rose without a wrap");

  enable_write_a: assert property (
    wr && paddr == OFF_ENABLES
    |=> s.overflow_irq_enable == $past(pwdata[POS_OVF]))
    else $error("enable bit did not take the written value");

  ctrl_write_a: assert property (
    wr && paddr == OFF_CONTROL
    |=> s.ctrl == $past(pwdata[POS_PRE_HI:POS_ON]))
    else $error("control write did not land");

  ctrl_read_a: assert property (
    setup && paddr == OFF_CONTROL |=> s.prdata == {26'h0, $past(s.ctrl)})
    else $error("control read back wrong");

  err_map_a: assert property (
    setup && !mapped(paddr) |=> s.pslverr && s.prdata == 32'h0000_0000)
    else $error("unmapped address not refused");

  ////////////////////////////////////////////////////////////////////////
  // counter halves seen from the bus

  lo_read_a: assert property (
    setup && paddr == OFF_COUNT_LO
    |=> s.prdata == {24'h0, $past(count[7:0])})
    else $error("low byte read not the live count");

  hi_read_a: assert property (
    setup && paddr == OFF_COUNT_HI
    |=> s.prdata == {24'h0, $past(count[15:8])})
    else $error("high byte read not the live count");

  lo_write_a: assert property (
    wr_lo |=> count[7:0] == $past(pwdata[7:0]) &&
              count[15:8] == $past(count[15:8]))
    else $error("low byte write touched the wrong byte");

  hi_write_a: assert property (
    wr_hi |=> count[15:8] == $past(pwdata[7:0]) &&
              count[7:0] == $past(count[7:0]))
    else $error("high byte write touched the wrong byte");

  lo_wins_a: assert property (
    wr_lo && ccp_clear |=> count[7:0] == $past(pwdata[7:0]))
    else $error("compare trigger beat a low byte write");

  hi_wins_a: assert property (
    wr_hi && ccp_clear |=> count[15:8] == $past(pwdata[7:0]))
    else $error("compare trigger beat a high byte write");

  ////////////////////////////////////////////////////////////////////////
  // prescaler, arming and sleep

  pre_step_a: assert property (
    src_tick && !wr_lo && !wr_hi |=> s.pre == $past(s.pre) + 3'h1)
    else $error("prescaler missed a source tick");

  pre_hold_a: assert property (
    !src_tick && !wr_lo && !wr_hi |=> s.pre == $past(s.pre))
    else $error("prescaler moved without a source tick");

  off_pre_a: assert property (
    !s.ctrl.counter_on && !wr_lo && !wr_hi |=> s.pre == $past(s.pre))
    else $error("prescaler moved while stopped");

  // the prescaler sits before the synchronizer, so sleep must not stall it
  sleep_pre_a: assert property (
    sleep && ext_mode && !s.ctrl.sync_disable && s.ctrl.counter_on &&
    s.armed && src_rise && !wr_lo && !wr_hi
    |=> s.pre == $past(s.pre) + 3'h1)
    else $error("prescaler stalled in sleep");

  arm_fall_a: assert property (
    $rose(s.armed) |-> $past(src_fall))
    else $error("armed without a falling edge");

  arm_drop_a: assert property (
    !s.ctrl.counter_on || !ext_mode |=> !s.armed)
    else $error("arming survived a stop or source change");

  // pin noise between rising edges must never reach the count
  ext_idle_a: assert property (
    ext_mode && !src_rise && !wr_lo && !wr_hi && !ccp_clear
    |=> count == $past(count))
    else $error("counter mode moved without a rising edge");

  async_sleep_a: assert property (
    sleep && ext_mode && s.ctrl.sync_disable && pre_tick &&
    !wr_lo && !wr_hi && !ccp_clear
    |=> count == $past(count) + 16'h0001)
    else $error("unsynchronized count stalled in sleep");

  // the instruction clock is gone in sleep, so timer mode must freeze
  timer_sleep_a: assert property (
    sleep && !ext_mode && !wr_lo && !wr_hi && !ccp_clear
    |=> count == $past(count))
    else $error("timer mode moved in sleep");

  wins_c: cover property (wr_lo && ccp_clear);
  wrap_c: cover property (inc && count == COUNT_MAX);
  ccp_c: cover property (ccp_clear && s.ctrl.counter_on);
  wake_c: cover property (sleep && ext_mode && s.ctrl.sync_disable && inc);
  clr_race_c: cover property (wr && paddr == OFF_FLAGS &&
                              inc && count == COUNT_MAX);

endmodule

// ===== stc_clk_src.sv
// far-side clock source model driving the two count input pins
`timescale 1ns/100ps
module stc_clk_src (
  input wire logic pclk, // sampling clock
  input wire logic go, // start a burst
  input wire logic use_osc, // burst on the oscillator pin
  input wire logic [7:0] n, // pulses in the burst
  input wire logic [3:0] half, // cycles per level, two or more
  output logic ext_clock_pin, // dedicated clock pin
  output logic osc_in_pin, // oscillator pin
  output logic busy // burst in progress
);
  logic lvl = 1'b0;
  logic nz = 1'b0;
  logic [8:0] k = '0;
  logic [3:0] c = '0;
  ////////////////////////////////////////////////////////////////////////
  // the unused pin toggles during a burst so a wrong pin choice shows up;
  // it rests low between bursts so a change of pin choice makes no edge
  always @(posedge pclk) begin
    nz <= (k != '0) ? ~nz : 1'b0;
    if (go && k == '0) begin
      k <= {n, 1'b0};
      c <= 4'h1;
    end else if (k != '0) begin
      if (c >= half) begin
        lvl <= ~lvl;
        k <= k - 9'h001;
        c <= 4'h1;
      end else begin
        c <= c + 4'h1;
      end
    end
  end
  assign busy = (k != '0);
  assign ext_clock_pin = use_osc ? nz : lvl;
  assign osc_in_pin = use_osc ? lvl : nz;
endmodule

// ===== testbench.sv
// self-checking bench for the 16-bit timer/counter
`timescale 1ns/100ps
`define CHK(a, e) \
  begin \
    samples_checked++; \
    if ((a) !== (e)) begin \
      bad_count++; \
      $display("Error t=%0t got %0h exp %0h", $time, (a), (e)); \
    end \
  end
module testbench;
  import stc_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, sleep, go, use_osc, busy;
  logic [7:0] paddr, n, d;
  logic [31:0] pwdata, prdata, rdat;
  logic [1:0] ccp_event;
  logic [3:0] half;
  logic [15:0] count_value, rcnt;
  logic osc_run, pin_force_input, pin_read_zero, timebase_valid, irq, wake;
  logic ext_clock_pin, osc_in_pin, rerr;
  int m, np;
  int bad_count = 0;
  int samples_checked = 0;
  stc_top i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .ext_clock_pin, .osc_in_pin,
    .sleep, .ccp_event, .osc_run, .pin_force_input, .pin_read_zero,
    .count_value, .timebase_valid, .irq, .wake);
  stc_clk_src i_src (.pclk, .go, .use_osc, .n, .half, .ext_clock_pin,
    .osc_in_pin, .busy);
  always #5 pclk = ~pclk;
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] cw(logic [1:0] p, logic o, s, c, on);
    return {26'h0, p, o, s, c, on};
  endfunction
  function automatic int exp_pre(int t, int p);
    return t >> p;
  endfunction
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] v);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, v};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic setcnt(input logic [15:0] v);
    apb(1'b1, OFF_COUNT_LO, {24'h0, v[7:0]});
    apb(1'b1, OFF_COUNT_HI, {24'h0, v[15:8]});
  endtask
  task automatic rdcnt();
    apb(1'b0, OFF_COUNT_LO, '0);
    rcnt[7:0] = rdat[7:0];
    apb(1'b0, OFF_COUNT_HI, '0);
    rcnt[15:8] = rdat[7:0];
  endtask
  task automatic ext(input logic [31:0] c, input logic o, s,
    input logic [15:0] st, ex, input int p, input logic wk);
    setcnt(st);
    {sleep, use_osc} <= {s, o};
    apb(1'b1, OFF_CONTROL, c);
    @(negedge pclk);
    `CHK(timebase_valid, !(c[1] && c[2]))
    `CHK(pin_read_zero, c[3])
    @(posedge pclk);
    {go, n, half} <= {1'b1, p[7:0], 4'($urandom_range(5, 2))};
    @(posedge pclk);
    go <= 1'b0;
    do begin
      @(posedge pclk);
    end while (busy === 1'b1);
    repeat (4) @(posedge pclk);
    @(negedge pclk);
    `CHK(wake, wk)
    apb(1'b1, OFF_CONTROL, '0);
    sleep <= 1'b0;
    rdcnt();
    `CHK(rcnt, ex)
  endtask
  task automatic stop_test;
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    #(50000 * 10);
    bad_count++;
    stop_test;
  end
  initial begin
    {psel, penable, pwrite, sleep, go, use_osc} = '0;
    // the count has no reset; a compare trigger gives it a known start
    ccp_event = 2'b01;
    {paddr, pwdata, n, half} = '0;
    void'($urandom(32'h48dcde1e));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    ccp_event <= '0;
    apb(1'b0, OFF_CONTROL, '0);
    `CHK(rdat, 32'h0)
    apb(1'b0, 8'h04, '0);
    `CHK(rerr, 1'b1)
    d = 8'($urandom) | 8'hC0;
    apb(1'b1, OFF_CONTROL, {24'h0, d & 8'hFE});
    apb(1'b0, OFF_CONTROL, '0);
    `CHK(rdat, {24'h0, d & 8'h3E})
    `CHK({osc_run, pin_force_input}, {2{d[3]}})
    // count must ride through a mid-run reset, control must not
    setcnt(16'hA55A);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdcnt();
    `CHK(rcnt, 16'hA55A)
    `CHK(count_value, 16'hA55A)
    apb(1'b0, OFF_CONTROL, '0);
    `CHK(rdat, 32'h0)
    apb(1'b1, OFF_COUNT_HI, 32'h3C);
    rdcnt();
    `CHK(rcnt, 16'h3C5A)
    for (int p = 0; p < 4; p++) begin
      m = $urandom_range(8, 1);
      setcnt('0);
      apb(1'b1, OFF_CONTROL, cw(p[1:0], 1'b0, p[0], 1'b0, 1'b1));
      repeat (8 * m - 3) @(posedge pclk);
      apb(1'b1, OFF_CONTROL, '0);
      rdcnt();
      `CHK(rcnt, 16'(exp_pre(8 * m, p)))
    end
    apb(1'b1, OFF_ENABLES, 32'h1);
    setcnt(16'hFFFE);
    apb(1'b1, OFF_CONTROL, cw(2'b00, 1'b0, 1'b0, 1'b0, 1'b1));
    apb(1'b1, OFF_CONTROL, '0);
    rdcnt();
    `CHK(rcnt, 16'h0001)
    @(negedge pclk);
    `CHK(irq, 1'b1)
    apb(1'b1, OFF_ENABLES, '0);
    @(negedge pclk);
    `CHK(irq, 1'b0)
    apb(1'b1, OFF_ENABLES, 32'h1);
    apb(1'b1, OFF_FLAGS, 32'h1);
    apb(1'b0, OFF_FLAGS, '0);
    `CHK({rdat[0], irq}, 2'b00)
    for (int i = 0; i < 4; i++) begin
      np = $urandom_range(9, 2);
      ext(cw(2'b00, i[0], i[1], 1'b1, 1'b1), i[0], 1'b0, '0,
        16'(np - 1), np, 1'b0);
    end
    ext(cw(2'b00, 1'b0, 1'b0, 1'b1, 1'b1), 1'b0, 1'b1, '0, '0, 5,
      1'b0);
    ext(cw(2'b00, 1'b1, 1'b1, 1'b1, 1'b1), 1'b1, 1'b1, 16'hFFFF,
      16'h0001, 3, 1'b1);
    apb(1'b1, OFF_FLAGS, 32'h1);
    // trigger lands on the wrap edge: count restarts, flag stays clear
    for (int i = 0; i < 2; i++) begin
      setcnt(16'hFFFF);
      apb(1'b1, OFF_CONTROL, cw(2'b00, 1'b0, 1'b0, 1'b0, 1'b1));
      ccp_event[i] <= 1'b1;
      @(posedge pclk);
      ccp_event <= '0;
      apb(1'b1, OFF_CONTROL, '0);
      rdcnt();
      `CHK(rcnt, 16'h0003)
      apb(1'b0, OFF_FLAGS, '0);
      `CHK(rdat, 32'h0)
    end
    setcnt(16'h1234);
    ccp_event <= 2'b11;
    apb(1'b1, OFF_COUNT_LO, 32'h77);
    ccp_event <= '0;
    rdcnt();
    `CHK(rcnt, 16'h0077)
    `CHK(count_value, 16'h0077)
    stop_test;
  end
endmodule
